/* hdl/evadc_map.vh */
// Register map, field positions and timing counts of the external voltage ADC
//
// Overview of operation
// - Results that raise the interrupt land in read-only byte 0xEF
// - Start bit at 0xD8 runs one conversion, interrupts
// - Background off at reset; runs on nonzero interval
// - Change flag when difference exceeds delta field
// - Flag at 0xF8 interrupts only if enabled
// - Full power: single and background conversions
// - Battery run: single only, no background
// - Sleep: background only, no single starts
// - Result register loads only on interrupt
// - Interrupt on single done or large change
// - No readable pending flag for converter interrupt
`ifndef EVADC_MAP_VH
`define EVADC_MAP_VH

// ====================================================================
// Register offsets
`define EVADC_ADDR_START     8'hd8
`define EVADC_ADDR_ENABLES   8'hec
`define EVADC_ADDR_RESULT    8'hef
`define EVADC_ADDR_DELTA     8'hf3
`define EVADC_ADDR_FLAGS     8'hf8
`define EVADC_ADDR_INTERVAL  8'hf9

// ====================================================================
// Field positions
`define EVADC_START_BIT      2
`define EVADC_FLAG_BIT       3
`define EVADC_DELTA_LSB      3
`define EVADC_DELTA_MSB      5
`define EVADC_PER_LSB        4
`define EVADC_PER_MSB        5

// ====================================================================
// Reset values
`define EVADC_RST_BYTE       8'h00

// ====================================================================
// Power states on the state input
`define EVADC_PS_FULL        2'h0
`define EVADC_PS_BATT        2'h1
`define EVADC_PS_SLEEP       2'h2

// ====================================================================
// Background interval counts in clock cycles, per interval code
`define EVADC_PER1_CYC       1000
`define EVADC_PER2_CYC       2000
`define EVADC_PER3_CYC       4000

`endif

/* hdl/evadc_tick.v */
// Background interval timer that emits one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
`include "evadc_map.vh"

module evadc_tick #(
    parameter integer PER1 = `EVADC_PER1_CYC,  // Cycles for code 1
    parameter integer PER2 = `EVADC_PER2_CYC,  // Cycles for code 2
    parameter integer PER3 = `EVADC_PER3_CYC   // Cycles for code 3
) (
    input  wire       clk_i,     // Core clock
    input  wire       rst_i,     // Asynchronous reset, high
    input  wire [1:0] sel_i,     // Interval code, zero stops
    output reg        tick_o     // One-cycle strobe
);

    reg  [31:0] cnt_ff;          // Cycles since last strobe
    reg  [1:0]  sel_ff;          // Code seen last cycle
    reg  [31:0] limit;           // Selected period

    // ================================================================
    // Period select
    always @* begin
        case (sel_i)
            2'h1:    limit = PER1;
            2'h2:    limit = PER2;
            2'h3:    limit = PER3;
            default: limit = 32'h0000_0000;
        endcase
    end

    // ================================================================
    // Counter; restarts whenever the code changes
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= 32'h0000_0000;
            sel_ff <= 2'h0;
            tick_o <= 1'b0;
        end else begin
            sel_ff <= sel_i;
            tick_o <= 1'b0;
            if (sel_i == 2'h0 || sel_i != sel_ff) begin
                cnt_ff <= 32'h0000_0000;      // Off or new period
            end else if (cnt_ff >= limit - 32'h0000_0001) begin
                cnt_ff <= 32'h0000_0000;
                tick_o <= 1'b1;                // Period elapsed
            end else begin
                cnt_ff <= cnt_ff + 32'h0000_0001;
            end
        end
    end

endmodule // evadc_tick

`default_nettype wire

/* hdl/evadc_top.v */
// External voltage ADC sequencer with its special function registers
`timescale 1ns/1ps
`default_nettype none
`include "evadc_map.vh"

module evadc_top #(
    parameter integer PER1 = `EVADC_PER1_CYC,  // Cycles for interval 1
    parameter integer PER2 = `EVADC_PER2_CYC,  // Cycles for interval 2
    parameter integer PER3 = `EVADC_PER3_CYC   // Cycles for interval 3
) (
    input  wire       CLK_I,          // Core clock, 50 MHz
    input  wire       RST_I,          // Asynchronous reset, high
    input  wire [7:0] SFR_ADDR_I,     // Register address
    input  wire [7:0] SFR_WDATA_I,    // Write data
    input  wire       SFR_WR_I,       // Write strobe
    input  wire       SFR_RD_I,       // Read strobe
    output reg  [7:0] SFR_RDATA_O,    // Read data, one cycle later
    input  wire [1:0] PWR_STATE_I,    // Full, battery run or sleep
    output reg        CONV_START_O,   // Start pulse to converter
    input  wire       CONV_DONE_I,    // Converter finished, pulse
    input  wire [7:0] CONV_CODE_I,    // Converter code, valid at done
    output reg        ADC_IRQ_O,      // Converter interrupt pulse
    output reg        PSM_IRQ_O       // Power management interrupt
);

    // ================================================================
    // States
    localparam [2:0] ST_IDLE   = 3'b001;  // Converter free
    localparam [2:0] ST_SINGLE = 3'b010;  // Software conversion
    localparam [2:0] ST_BACK   = 3'b100;  // Background conversion

    // ================================================================
    // Registers
    reg  [7:0] start_ff;      // Start register storage
    reg  [7:0] enables_ff;    // Power event enables
    reg  [7:0] result_ff;     // Reported result
    reg  [7:0] delta_ff;      // Delta register
    reg        flag_ff;       // Change flag
    reg  [7:0] interval_ff;   // Interval register
    reg  [7:0] ref_ff;        // Last reported code
    reg  [2:0] state_ff;      // Sequencer state
    reg        bg_pend_ff;    // Background strobe waiting
    reg  [2:0] nxt_state;     // Next sequencer state
    reg        nxt_start;     // Next converter start

    wire       wr_start;      // Write to start register
    wire       wr_flags;      // Write to flag register
    wire       bg_tick;       // Interval strobe
    wire       bg_allowed;    // Background permitted now
    wire       single_ok;     // Single start permitted now
    wire [7:0] diff;          // Absolute code difference
    wire       big_change;    // Difference exceeds delta
    wire       single_done;   // Software conversion ends
    wire       back_done;     // Background conversion ends
    wire       irq_evt;       // Converter interrupt event
    wire       flag_set;      // Change flag set event

    // ================================================================
    // Register read decode
    function [7:0] rd_mux;
        input [7:0] addr;
        begin
            case (addr)
                `EVADC_ADDR_START:    rd_mux = start_ff;
                `EVADC_ADDR_ENABLES:  rd_mux = enables_ff;
                `EVADC_ADDR_RESULT:   rd_mux = result_ff;
                `EVADC_ADDR_DELTA:    rd_mux = delta_ff;
                `EVADC_ADDR_FLAGS:
                    rd_mux = {4'h0, flag_ff, 3'h0};
                `EVADC_ADDR_INTERVAL: rd_mux = interval_ff;
                default:              rd_mux = 8'h00;
            endcase
        end
    endfunction

    // ================================================================
    // Mode gating and compare
    assign wr_start   = SFR_WR_I && (SFR_ADDR_I == `EVADC_ADDR_START);
    assign wr_flags   = SFR_WR_I && (SFR_ADDR_I == `EVADC_ADDR_FLAGS);
    // Background only in full power and sleep
    assign bg_allowed = (PWR_STATE_I == `EVADC_PS_FULL) ||
                        (PWR_STATE_I == `EVADC_PS_SLEEP);
    // Single starts only while the core runs
    assign single_ok  = (PWR_STATE_I != `EVADC_PS_SLEEP);
    assign diff       = (CONV_CODE_I > ref_ff) ? CONV_CODE_I - ref_ff
                                               : ref_ff - CONV_CODE_I;
    assign big_change = diff > {5'h00,
                        delta_ff[`EVADC_DELTA_MSB:`EVADC_DELTA_LSB]};
    assign single_done = (state_ff == ST_SINGLE) && CONV_DONE_I;
    assign back_done   = (state_ff == ST_BACK) && CONV_DONE_I;
    assign flag_set    = back_done && big_change;
    assign irq_evt     = single_done || flag_set;

    // ================================================================
    // Interval timer, stopped while the field is zero
    evadc_tick #(
        .PER1   (PER1),
        .PER2   (PER2),
        .PER3   (PER3)
    ) u_tick (
        .clk_i  (CLK_I),
        .rst_i  (RST_I),
        .sel_i  (interval_ff[`EVADC_PER_MSB:`EVADC_PER_LSB]),
        .tick_o (bg_tick)
    );

    // ================================================================
    // Sequencer next state
    always @* begin
        nxt_state = state_ff;
        nxt_start = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                // Software request has priority over background
                if (start_ff[`EVADC_START_BIT]) begin
                    nxt_state = ST_SINGLE;
                    nxt_start = 1'b1;
                end else if (bg_pend_ff && bg_allowed) begin
                    nxt_state = ST_BACK;
                    nxt_start = 1'b1;
                end
            end
            ST_SINGLE: begin
                if (CONV_DONE_I) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_BACK: begin
                if (CONV_DONE_I) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // ================================================================
    // Sequencer and strobes
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_ff     <= ST_IDLE;
            CONV_START_O <= 1'b0;
            bg_pend_ff   <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            CONV_START_O <= nxt_start;
            // Hold a strobe that arrives while busy; drop it if barred
            if (!bg_allowed) begin
                bg_pend_ff <= 1'b0;
            end else if (bg_tick) begin
                bg_pend_ff <= 1'b1;
            end else if (nxt_state == ST_BACK && state_ff == ST_IDLE) begin
                bg_pend_ff <= 1'b0;
            end
        end
    end

    // ================================================================
    // Software written registers
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            start_ff    <= `EVADC_RST_BYTE;
            enables_ff  <= `EVADC_RST_BYTE;
            delta_ff    <= `EVADC_RST_BYTE;
            interval_ff <= `EVADC_RST_BYTE;
        end else begin
            if (wr_start) begin
                start_ff <= SFR_WDATA_I;
                // Start refused while the core sleeps
                // Pending bit survives the write unless its done is now
                start_ff[`EVADC_START_BIT] <= single_ok &&
                    (SFR_WDATA_I[`EVADC_START_BIT] ||
                     (start_ff[`EVADC_START_BIT] && !single_done));
            end else if (single_done) begin
                start_ff[`EVADC_START_BIT] <= 1'b0;        // Self clear
            end
            if (SFR_WR_I && SFR_ADDR_I == `EVADC_ADDR_ENABLES) begin
                enables_ff <= SFR_WDATA_I;
            end
            if (SFR_WR_I && SFR_ADDR_I == `EVADC_ADDR_DELTA) begin
                delta_ff <= SFR_WDATA_I;
            end
            if (SFR_WR_I && SFR_ADDR_I == `EVADC_ADDR_INTERVAL) begin
                interval_ff <= SFR_WDATA_I;
            end
        end
    end

    // ================================================================
    // Result, reference and converter interrupt
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            result_ff <= `EVADC_RST_BYTE;
            ref_ff    <= `EVADC_RST_BYTE;
            ADC_IRQ_O <= 1'b0;
        end else begin
            // No pending bit: only the pulse and the new result
            ADC_IRQ_O <= irq_evt;
            if (irq_evt) begin
                result_ff <= CONV_CODE_I;
                ref_ff    <= CONV_CODE_I;
            end
        end
    end

    // ================================================================
    // Change flag, power interrupt and read port
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            flag_ff     <= 1'b0;
            PSM_IRQ_O   <= 1'b0;
            SFR_RDATA_O <= 8'h00;
        end else begin
            // Set wins over a clear in the same cycle
            if (flag_set) begin
                flag_ff <= 1'b1;
            end else if (wr_flags && !SFR_WDATA_I[`EVADC_FLAG_BIT]) begin
                flag_ff <= 1'b0;
            end
            PSM_IRQ_O <= (flag_ff || flag_set) &&
                         enables_ff[`EVADC_FLAG_BIT];
            if (SFR_RD_I) begin
                SFR_RDATA_O <= rd_mux(SFR_ADDR_I);
            end
        end
    end

endmodule // evadc_top

`default_nettype wire

/* verification/evadc_top_assertions.sv */
// Port checker for the external voltage ADC sequencer
`timescale 1ns/1ps
`default_nettype none
module evadc_sva (
    input wire logic       CLK_I,
    input wire logic       RST_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic       SFR_WR_I,
    input wire logic       SFR_RD_I,
    input wire logic [7:0] SFR_RDATA_O,
    input wire logic [1:0] PWR_STATE_I,
    input wire logic       CONV_START_O,
    input wire logic       CONV_DONE_I,
    input wire logic [7:0] CONV_CODE_I,
    input wire logic       ADC_IRQ_O,
    input wire logic       PSM_IRQ_O
);
    // ========
    // Decode
    wire [7:0] a = SFR_ADDR_I;
    wire wr_st = SFR_WR_I && a == 8'hd8 && SFR_WDATA_I[2]; // Start write
    wire wr_cf = SFR_WR_I && (a == 8'hec || a == 8'hf8);   // Flag setup
    wire rd_rs = SFR_RD_I && a == 8'hef;
    wire rd_fl = SFR_RD_I && a == 8'hf8;
    wire rd_un = SFR_RD_I &&
        !(a inside {8'hd8, 8'hec, 8'hef, 8'hf3, 8'hf8, 8'hf9});
    logic       busy_ff; // Conversion in flight
    logic [7:0] code_ff; // Code at last done
    logic [7:0] res_ff;  // Result software sees
    wire       dn_bz = CONV_DONE_I && (busy_ff || CONV_START_O);
    wire [7:0] exp_rs = ADC_IRQ_O ? code_ff : res_ff;
    // Shadow of converter and result
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            busy_ff <= 1'b0;
            code_ff <= 8'h00;
            res_ff <= 8'h00;
        end else begin
            busy_ff <= dn_bz ? 1'b0 : (CONV_START_O ? 1'b1 : busy_ff);
            code_ff <= CONV_DONE_I ? CONV_CODE_I : code_ff;
            res_ff <= exp_rs;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // ========
    // Properties
    property p_st_one; CONV_START_O |=> !CONV_START_O; endproperty
    a_st_one: assert property (p_st_one) else $error("long start");
    property p_st_take;
        wr_st && PWR_STATE_I != 2'h2 && !busy_ff && !CONV_START_O
        |=> ##1 CONV_START_O;
    endproperty
    a_st_take: assert property (p_st_take)
        else $error("no start");
    property p_irq_src; ADC_IRQ_O |-> $past(dn_bz); endproperty
    a_irq_src: assert property (p_irq_src)
        else $error("stray irq");
    property p_irq_one; ADC_IRQ_O |=> !ADC_IRQ_O; endproperty
    a_irq_one: assert property (p_irq_one)
        else $error("long irq");
    property p_res; $past(rd_rs) |-> SFR_RDATA_O == $past(exp_rs); endproperty
    a_res: assert property (p_res) else $error("bad result");
    property p_unm; $past(rd_un) |-> SFR_RDATA_O == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped data");
    property p_flg; $past(rd_fl) |-> (SFR_RDATA_O & 8'hf7) == 8'h00; endproperty
    a_flg: assert property (p_flg) else $error("extra flag");
    property p_hold; !$past(SFR_RD_I) |-> $stable(SFR_RDATA_O); endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    property p_psm;
        $changed(PSM_IRQ_O) |-> ADC_IRQ_O || $past(ADC_IRQ_O) ||
            $past(wr_cf) || $past(wr_cf, 2);
    endproperty
    a_psm: assert property (p_psm) else $error("psm moved");
endmodule // evadc_sva
bind evadc_top evadc_sva u_sva (.CLK_I(CLK_I), .RST_I(RST_I),
    .SFR_ADDR_I(SFR_ADDR_I), .SFR_WDATA_I(SFR_WDATA_I), .SFR_WR_I(SFR_WR_I),
    .SFR_RD_I(SFR_RD_I), .SFR_RDATA_O(SFR_RDATA_O),
    .PWR_STATE_I(PWR_STATE_I), .CONV_START_O(CONV_START_O),
    .CONV_DONE_I(CONV_DONE_I), .CONV_CODE_I(CONV_CODE_I),
    .ADC_IRQ_O(ADC_IRQ_O), .PSM_IRQ_O(PSM_IRQ_O));
`default_nettype wire

/* verification/evadc_top_tb.sv */
// Self-checking bench for the external voltage ADC sequencer
`timescale 1ns/1ps
`default_nettype none
module evadc_top_tb;
    logic       clk = 0, rst = 1, wr = 0, rd = 0, dn = 0, got;
    logic [7:0] ad = 0, wd = 0, cd = 0, rv, dl;
    logic [1:0] ps = 0;
    wire  [7:0] rdat;
    wire        st, irq, psm;
    int         failures = 0, checks = 0, cyc = 0, i;
    // Register rows: address, write value, read back
    logic [7:0] ra [7] = '{8'hd8, 8'hec, 8'hf3, 8'hf9, 8'hef, 8'h10, 8'hf8};
    logic [7:0] rw [7] = '{8'h03, 8'h08, 8'h38, 8'h00, 8'haa, 8'h55, 8'hff};
    logic [7:0] re [7] = '{8'h03, 8'h08, 8'h38, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] bc [3] = '{8'h5c, 8'h5d, 8'h5f}; // Background codes
    evadc_top #(.PER1(20), .PER2(30), .PER3(40)) u_dut (
        .CLK_I(clk), .RST_I(rst), .SFR_ADDR_I(ad), .SFR_WDATA_I(wd),
        .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_RDATA_O(rdat),
        .PWR_STATE_I(ps), .CONV_START_O(st), .CONV_DONE_I(dn),
        .CONV_CODE_I(cd), .ADC_IRQ_O(irq), .PSM_IRQ_O(psm));
    initial forever #10 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            close_out;
        end
    end
    task chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, s, e);
        end
    endtask
    task wrt(input logic [7:0] a, input logic [7:0] w);
        @(posedge clk);
        {ad, wd, wr} <= {a, w, 1'b1};
        @(posedge clk);
        wr <= 0;
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        {ad, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 0;
        #1 chk(rdat & m, e);
    endtask
    // Wait up to n cycles for a start pulse
    task wst(input int n, input logic e);
        int k;
        got = 0;
        for (k = 0; k < n && !got; k++) begin
            @(posedge clk);
            #1 got = (st === 1'b1);
        end
        chk({7'h0, got}, {7'h0, e});
    endtask
    // Converter finishes with code c
    task cnv(input logic [7:0] c, input logic e);
        @(posedge clk);
        {dn, cd} <= {1'b1, c};
        @(posedge clk);
        dn <= 0;
        #1 chk({7'h0, irq}, {7'h0, e});
    endtask
    task close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        for (i = 0; i < 7; i++) begin
            rdc(ra[i], 8'hff, 8'h00);
            wrt(ra[i], rw[i]);
            rdc(ra[i], 8'hff, re[i]);
        end
        // Single conversion at full power
        wrt(8'hd8, 8'h04);
        wst(5, 1);
        rdc(8'hd8, 8'h04, 8'h04);
        cnv(8'h5a, 1);
        rdc(8'hef, 8'hff, 8'h5a);
        rdc(8'hd8, 8'h04, 8'h00);
        // Background with delta 2, set up in order
        rv = 8'h5a;
        wrt(8'hf3, 8'h10);
        wrt(8'hec, 8'h08);
        wrt(8'hf9, 8'h10);
        for (i = 0; i < 3; i++) begin
            dl = bc[i] > rv ? bc[i] - rv : rv - bc[i];
            wst(30, 1);
            cnv(bc[i], dl > 2);
            if (dl > 2) rv = bc[i];
            rdc(8'hef, 8'hff, rv);
            rdc(8'hf8, 8'hff, {4'h0, i > 0, 3'h0});
            chk({7'h0, psm}, {7'h0, i > 0});
        end
        // Masking and clearing the change flag
        wrt(8'hf9, 8'h00);
        wrt(8'hec, 8'h00);
        rdc(8'hf8, 8'hff, 8'h08);
        chk({7'h0, psm}, 8'h00);
        wrt(8'hf8, 8'h00);
        wrt(8'hec, 8'h08);
        rdc(8'hf8, 8'hff, 8'h00);
        chk({7'h0, psm}, 8'h00);
        // Battery run: singles only
        @(posedge clk);
        ps <= 2'h1;
        wrt(8'hf9, 8'h10);
        wst(50, 0);
        wrt(8'hd8, 8'h04);
        wst(5, 1);
        cnv(8'h33, 1);
        rdc(8'hef, 8'hff, 8'h33);
        // Sleep: background only; timer restarted so the strobe is seen
        wrt(8'hf9, 8'h00);
        @(posedge clk);
        ps <= 2'h2;
        wrt(8'hd8, 8'h04);
        rdc(8'hd8, 8'h04, 8'h00);
        wrt(8'hf9, 8'h10);
        wst(30, 1);
        cnv(8'h35, 0);
        // Reset in mid-run
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        {rst, ps} <= 3'h0;
        rdc(8'hf9, 8'hff, 8'h00);
        rdc(8'hef, 8'hff, 8'h00);
        wst(50, 0);
        close_out;
    end
endmodule // evadc_top_tb
`default_nettype wire
